// >>> logic/mbst_consts.svh
`ifndef MBST_CONSTS_SVH
`define MBST_CONSTS_SVH
// Notes on behaviour
// - pull-ups on data in and mode select keep an unused port idle
// - inputs sampled on test clock rise; serial output changes on fall
// - controller advances each test clock rise by mode select level
// - instruction picks one register; input at msb, output from lsb
// - serial output driven only in shift-IR and shift-DR states
// - five high mode select edges reach reset state; logic inactive there
// - idle holds while mode select low; leads to DR or IR scan
// - select-DR-scan leaves all test data registers unchanged
// - capture-DR loads selected register; boundary register snapshots pins
// - shift-DR shifts one bit per test clock, in at top, out at bottom
// - exit1 leads to update; pause suspends; exit2 may resume shifting
// - boundary parallel outputs change only in update-DR
// - instruction shifts in during shift-IR, takes effect in update-IR
// - internal power-up reset; serial output starts high impedance
// - eight-bit instruction register reset to identification instruction
// - capture-IR loads the two low bits with binary 01
// - one-bit bypass register cleared when bypass instruction takes effect
// - boundary-scan register is 121 bits long
// - identification instruction captures fixed 32-bit code, shifts it out
// - bypass instruction puts bypass bit between input and output

// ----------------------------------------------------------------
// register sizes
// ----------------------------------------------------------------
`define MBST_IR_WIDTH 8
`define MBST_BSR_WIDTH 121
`define MBST_ID_WIDTH 32
`define MBST_IR_CAPTURE 8'h01

// ----------------------------------------------------------------
// instruction codes
// ----------------------------------------------------------------
`define MBST_INS_EXTEST 8'h00
`define MBST_INS_IDCODE 8'h01
`define MBST_INS_SAMPLE 8'h05
`define MBST_INS_CLAMP 8'h07
`define MBST_INS_HIGHZ 8'h08
`define MBST_INS_BYPASS 8'hff

// ----------------------------------------------------------------
// synchroniser reset levels (idle pin levels)
// ----------------------------------------------------------------
`define MBST_TCK_IDLE 1'b0
`define MBST_TMS_IDLE 1'b1
`define MBST_TDI_IDLE 1'b1
`endif

// >>> logic/mbst_pkg.sv
`include "mbst_consts.svh"
package mbst_pkg;

  // controller states, standard encoding
  typedef enum logic [3:0] {
    MBST_TLR = 4'b1111,
    MBST_RTI = 4'b1100,
    MBST_SEL_DR = 4'b0111,
    MBST_CAP_DR = 4'b0110,
    MBST_SH_DR = 4'b0010,
    MBST_EX1_DR = 4'b0001,
    MBST_PAU_DR = 4'b0011,
    MBST_EX2_DR = 4'b0000,
    MBST_UPD_DR = 4'b0101,
    MBST_SEL_IR = 4'b0100,
    MBST_CAP_IR = 4'b1110,
    MBST_SH_IR = 4'b1010,
    MBST_EX1_IR = 4'b1001,
    MBST_PAU_IR = 4'b1011,
    MBST_EX2_IR = 4'b1000,
    MBST_UPD_IR = 4'b1101
  } mbst_state_t;

  // data register selected by the active instruction
  typedef enum logic [1:0] {
    MBST_DR_BYPASS = 2'b00,
    MBST_DR_ID = 2'b01,
    MBST_DR_BSR = 2'b10
  } mbst_dr_sel_t;

  // test port pins coming in from the board
  typedef struct packed {
    logic tck;
    logic tms;
    logic tdi;
  } mbst_pins_t;

  // serial output pin with its enable
  typedef struct packed {
    logic data;
    logic oe;
  } mbst_tdo_t;

endpackage : mbst_pkg

// >>> logic/mbst_scan_reg.sv
`timescale 1ns/1ps
`include "mbst_consts.svh"
// shift register with parallel capture and an update latch
module mbst_scan_reg #(
  parameter int WIDTH = 8,
  parameter logic [WIDTH-1:0] INIT = '0
) (
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic load_init,
  input wire logic capture,
  input wire logic [WIDTH-1:0] cap_data,
  input wire logic shift,
  input wire logic shift_in,
  input wire logic update,
  output logic [WIDTH-1:0] shift_q,
  output logic [WIDTH-1:0] update_q
);

  // ----------------------------------------------------------------
  // elaboration check
  // ----------------------------------------------------------------
  if (WIDTH < 2) begin : g_bad_width
    $error("mbst_scan_reg needs WIDTH of at least 2");
  end

  // ----------------------------------------------------------------
  // shift stage
  // ----------------------------------------------------------------
  // capture loads in parallel, shift moves towards the lsb
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      shift_q <= '0;
    end else if (capture) begin
      shift_q <= cap_data;
    end else if (shift) begin
      shift_q <= {shift_in, shift_q[WIDTH-1:1]};
    end
  end

  // ----------------------------------------------------------------
  // update latch
  // ----------------------------------------------------------------
  // reset value applies on power-up and on request
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      update_q <= INIT;
    end else if (load_init) begin
      update_q <= INIT;
    end else if (update) begin
      update_q <= shift_q;
    end
  end

endmodule : mbst_scan_reg

// >>> logic/mbst_tap_top.sv
`timescale 1ns/1ps
`include "mbst_consts.svh"
// boundary-scan test access port, sampled on the memory clock
module mbst_tap_top
  import mbst_pkg::*;
#(
  parameter int BSR_WIDTH = `MBST_BSR_WIDTH,
  // identification code: value is arbitrary, lsb kept at one
  parameter logic [`MBST_ID_WIDTH-1:0] ID_CODE = 32'h0a5c_3e01
) (
  input wire logic mclk,
  input wire logic reset_n,
  input wire mbst_pins_t tap_pins,
  input wire logic [BSR_WIDTH-1:0] pin_state,
  output mbst_tdo_t tdo,
  output logic [BSR_WIDTH-1:0] bsr_drive,
  output logic ring_drive_en,
  output logic ring_highz,
  output mbst_state_t tap_state
);

  // ----------------------------------------------------------------
  // elaboration check
  // ----------------------------------------------------------------
  if (BSR_WIDTH != `MBST_BSR_WIDTH) begin : g_bad_bsr
    $error("boundary register must be 121 cells");
  end
  if (ID_CODE[0] != 1'b1) begin : g_bad_id
    $error("identification code lsb must be one");
  end
  if (`MBST_IR_WIDTH != 8) begin : g_bad_ir
    $error("instruction decode expects eight bits");
  end
  if ((`MBST_IR_CAPTURE & 8'h03) != 8'h01) begin : g_bad_cap
    $error("capture pattern low bits must be 01");
  end
  if (`MBST_ID_WIDTH != 32) begin : g_bad_idw
    $error("identification register must be 32 bits");
  end

  // ----------------------------------------------------------------
  // functions
  // ----------------------------------------------------------------
  // sixteen-state transition graph, chosen by mode select only
  function automatic mbst_state_t next_of(input mbst_state_t s,
                                          input logic m);
    case (s)
      MBST_TLR: next_of = m ? MBST_TLR : MBST_RTI;
      MBST_RTI: next_of = m ? MBST_SEL_DR : MBST_RTI;
      MBST_SEL_DR: next_of = m ? MBST_SEL_IR : MBST_CAP_DR;
      MBST_CAP_DR: next_of = m ? MBST_EX1_DR : MBST_SH_DR;
      MBST_SH_DR: next_of = m ? MBST_EX1_DR : MBST_SH_DR;
      MBST_EX1_DR: next_of = m ? MBST_UPD_DR : MBST_PAU_DR;
      MBST_PAU_DR: next_of = m ? MBST_EX2_DR : MBST_PAU_DR;
      MBST_EX2_DR: next_of = m ? MBST_UPD_DR : MBST_SH_DR;
      MBST_UPD_DR: next_of = m ? MBST_SEL_DR : MBST_RTI;
      MBST_SEL_IR: next_of = m ? MBST_TLR : MBST_CAP_IR;
      MBST_CAP_IR: next_of = m ? MBST_EX1_IR : MBST_SH_IR;
      MBST_SH_IR: next_of = m ? MBST_EX1_IR : MBST_SH_IR;
      MBST_EX1_IR: next_of = m ? MBST_UPD_IR : MBST_PAU_IR;
      MBST_PAU_IR: next_of = m ? MBST_EX2_IR : MBST_PAU_IR;
      MBST_EX2_IR: next_of = m ? MBST_UPD_IR : MBST_SH_IR;
      MBST_UPD_IR: next_of = m ? MBST_SEL_DR : MBST_RTI;
      default: next_of = MBST_TLR;
    endcase
  endfunction : next_of

  // which data register an instruction places in the scan path
  function automatic mbst_dr_sel_t dr_of(input logic [7:0] ins);
    case (ins)
      `MBST_INS_EXTEST: dr_of = MBST_DR_BSR;
      `MBST_INS_SAMPLE: dr_of = MBST_DR_BSR;
      `MBST_INS_IDCODE: dr_of = MBST_DR_ID;
      default: dr_of = MBST_DR_BYPASS;
    endcase
  endfunction : dr_of

  // only the two shift states drive the serial output
  function automatic logic is_shift(input mbst_state_t s);
    is_shift = (s == MBST_SH_IR) || (s == MBST_SH_DR);
  endfunction : is_shift

  // instructions that hand the ring pins to the boundary latch
  function automatic logic ring_owned(input logic [7:0] ins);
    case (ins)
      `MBST_INS_EXTEST: ring_owned = 1'b1;
      `MBST_INS_CLAMP: ring_owned = 1'b1;
      default: ring_owned = 1'b0;
    endcase
  endfunction : ring_owned

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  // idle levels act as the internal pull-ups on mode select and data in
  localparam logic [2:0] PIN_IDLE = {`MBST_TCK_IDLE, `MBST_TMS_IDLE,
                                     `MBST_TDI_IDLE};
  logic [2:0] pin_meta;
  logic [2:0] pin_sync;
  logic tck_d;

  // two flops on every pin before any logic reads it
  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++) begin : g_pin_sync
      always_ff @(posedge mclk) begin
        if (!reset_n) begin
          pin_meta[gi] <= PIN_IDLE[gi];
          pin_sync[gi] <= PIN_IDLE[gi];
        end else begin
          pin_meta[gi] <= tap_pins[gi];
          pin_sync[gi] <= pin_meta[gi];
        end
      end
    end
  endgenerate

  // synchronised pin levels
  logic tck_s;
  logic tms_s;
  logic tdi_s;
  assign tck_s = pin_sync[2];
  assign tms_s = pin_sync[1];
  assign tdi_s = pin_sync[0];

  // edge finder on the synchronised test clock
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      tck_d <= `MBST_TCK_IDLE;
    end else begin
      tck_d <= tck_s;
    end
  end

  // one-cycle pulses on each test clock edge
  logic tck_rise;
  logic tck_fall;
  assign tck_rise = tck_s & ~tck_d;
  assign tck_fall = ~tck_s & tck_d;

  // ring snapshot synchroniser, pins are asynchronous to mclk
  logic [BSR_WIDTH-1:0] ring_meta;
  logic [BSR_WIDTH-1:0] ring_sync;
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      ring_meta <= '0;
      ring_sync <= '0;
    end else begin
      ring_meta <= pin_state;
      ring_sync <= ring_meta;
    end
  end

  // ----------------------------------------------------------------
  // controller
  // ----------------------------------------------------------------
  // state register and its next value from the graph
  mbst_state_t state;
  mbst_state_t next_state;
  assign next_state = next_of(state, tms_s);

  // power-up reset lands in test-logic-reset, tdo stays off
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      state <= MBST_TLR;
    end else if (tck_rise) begin
      state <= next_state;
    end
  end

  // state seen outside straight from the flop
  assign tap_state = state;

  // ----------------------------------------------------------------
  // instruction register
  // ----------------------------------------------------------------
  // shift stage, active instruction and their strobes
  logic [`MBST_IR_WIDTH-1:0] ir_shift;
  logic [`MBST_IR_WIDTH-1:0] ir_active;
  logic ir_capture;
  logic ir_shift_en;
  logic ir_update;
  logic in_reset;

  assign in_reset = (state == MBST_TLR);
  assign ir_capture = tck_rise && (state == MBST_CAP_IR);
  assign ir_shift_en = tck_rise && (state == MBST_SH_IR);
  assign ir_update = tck_rise && (state == MBST_UPD_IR);

  // instruction stage, reloaded while in test-logic-reset
  mbst_scan_reg #(
    .WIDTH(`MBST_IR_WIDTH),
    .INIT(`MBST_INS_IDCODE)
  ) u_ir (
    .mclk(mclk),
    .reset_n(reset_n),
    .load_init(in_reset),
    .capture(ir_capture),
    .cap_data(`MBST_IR_CAPTURE),
    .shift(ir_shift_en),
    .shift_in(tdi_s),
    .update(ir_update),
    .shift_q(ir_shift),
    .update_q(ir_active)
  );

  // active instruction picks the data register
  mbst_dr_sel_t dr_sel;
  assign dr_sel = dr_of(ir_active);

  // ----------------------------------------------------------------
  // data register enables
  // ----------------------------------------------------------------
  // only capture, shift and update states touch data registers
  logic dr_capture;
  logic dr_shift;
  logic dr_update;
  assign dr_capture = tck_rise && (state == MBST_CAP_DR);
  assign dr_shift = tck_rise && (state == MBST_SH_DR);
  assign dr_update = tck_rise && (state == MBST_UPD_DR);

  // ----------------------------------------------------------------
  // bypass register
  // ----------------------------------------------------------------
  logic bypass_bit;
  // cleared by the bypass instruction, zero on capture
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      bypass_bit <= 1'b0;
    end else if (ir_update && (ir_shift == `MBST_INS_BYPASS)) begin
      bypass_bit <= 1'b0;
    end else if (dr_sel == MBST_DR_BYPASS) begin
      if (dr_capture) begin
        bypass_bit <= 1'b0;
      end else if (dr_shift) begin
        bypass_bit <= tdi_s;
      end
    end
  end

  // ----------------------------------------------------------------
  // identification register
  // ----------------------------------------------------------------
  // fixed code captured, never updated
  logic [`MBST_ID_WIDTH-1:0] id_shift;
  mbst_scan_reg #(
    .WIDTH(`MBST_ID_WIDTH),
    .INIT(ID_CODE)
  ) u_id (
    .mclk(mclk),
    .reset_n(reset_n),
    .load_init(1'b0),
    .capture(dr_capture && (dr_sel == MBST_DR_ID)),
    .cap_data(ID_CODE),
    .shift(dr_shift && (dr_sel == MBST_DR_ID)),
    .shift_in(tdi_s),
    .update(1'b0),
    .shift_q(id_shift),
    .update_q()
  );

  // ----------------------------------------------------------------
  // boundary-scan register
  // ----------------------------------------------------------------
  // shift stage, pin latch and path select
  logic [BSR_WIDTH-1:0] bsr_shift;
  logic [BSR_WIDTH-1:0] bsr_latch;
  logic bsr_sel;
  assign bsr_sel = (dr_sel == MBST_DR_BSR);

  // captures the ring, update drives the pins
  mbst_scan_reg #(
    .WIDTH(BSR_WIDTH),
    .INIT('0)
  ) u_bsr (
    .mclk(mclk),
    .reset_n(reset_n),
    .load_init(1'b0),
    .capture(dr_capture && bsr_sel),
    .cap_data(ring_sync),
    .shift(dr_shift && bsr_sel),
    .shift_in(tdi_s),
    .update(dr_update && bsr_sel),
    .shift_q(bsr_shift),
    .update_q(bsr_latch)
  );

  // latched cells go straight to the ring
  assign bsr_drive = bsr_latch;

  // ----------------------------------------------------------------
  // ring mode outputs
  // ----------------------------------------------------------------
  // reset state holds the identification instruction, so logic is idle
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      ring_drive_en <= 1'b0;
    end else begin
      ring_drive_en <= ring_owned(ir_active);
    end
  end

  // outputs float while the high impedance instruction is active
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      ring_highz <= 1'b0;
    end else begin
      ring_highz <= (ir_active == `MBST_INS_HIGHZ);
    end
  end

  // ----------------------------------------------------------------
  // serial output
  // ----------------------------------------------------------------
  // lsb of the data register that the instruction selects
  logic dr_lsb;
  always_comb begin
    case (dr_sel)
      MBST_DR_ID: dr_lsb = id_shift[0];
      MBST_DR_BSR: dr_lsb = bsr_shift[0];
      default: dr_lsb = bypass_bit;
    endcase
  end

  // the instruction stage takes the path while in shift-IR
  logic scan_lsb;
  always_comb begin
    if (state == MBST_SH_IR) begin
      scan_lsb = ir_shift[0];
    end else begin
      scan_lsb = dr_lsb;
    end
  end

  // data and enable move only on the falling test clock edge
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      tdo <= '0;
    end else if (tck_fall) begin
      tdo.data <= scan_lsb;
      tdo.oe <= is_shift(state);
    end
  end

endmodule : mbst_tap_top

// >>> sim/mbst_tap_sva.sv
`timescale 1ns/1ps
// ----------------------------------------------------------------
// port checker for the test access port
// ----------------------------------------------------------------
module mbst_tap_sva
  import mbst_pkg::*;
#(
  parameter int BSR_WIDTH = 121
) (
  input wire logic mclk,
  input wire logic reset_n,
  input wire mbst_pins_t tap_pins,
  input wire logic [BSR_WIDTH-1:0] pin_state,
  input wire mbst_tdo_t tdo,
  input wire logic [BSR_WIDTH-1:0] bsr_drive,
  input wire logic ring_drive_en,
  input wire logic ring_highz,
  input wire mbst_state_t tap_state
);
  logic [1:0] tck_sync;
  logic [1:0] tms_sync;
  logic tck_last;
  logic [2:0] hi_cnt;
  logic rise;
  logic fall;

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!reset_n);

  // test clock and mode select seen through two flops
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      tck_sync <= 2'h0;
      tms_sync <= 2'h3;
      tck_last <= 1'b0;
    end else begin
      tck_sync <= {tck_sync[0], tap_pins.tck};
      tms_sync <= {tms_sync[0], tap_pins.tms};
      tck_last <= tck_sync[1];
    end
  end

  // edges of the seen test clock
  assign rise = tck_sync[1] & ~tck_last;
  assign fall = ~tck_sync[1] & tck_last;

  // run length of rises with mode select high, saturating
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      hi_cnt <= 3'h0;
    end else if (rise && !tms_sync[1]) begin
      hi_cnt <= 3'h0;
    end else if (rise && hi_cnt != 3'h7) begin
      hi_cnt <= hi_cnt + 3'h1;
    end
  end

  AST_FIVE_HIGH: assert property (
    rise && tms_sync[1] && hi_cnt >= 3'h4 |-> ##[1:3] tap_state == MBST_TLR)
    else $error("reset state not reached after five high rises");
  AST_TLR_QUIET: assert property (
    tap_state == MBST_TLR [*3] |-> !ring_drive_en && !ring_highz && !tdo.oe)
    else $error("test logic active in reset state");
  AST_IDLE_HOLD: assert property (
    rise && !tms_sync[1] && tap_state == MBST_RTI |=> tap_state == MBST_RTI [*4])
    else $error("idle state left with mode select low");
  AST_STATE_ON_RISE: assert property (
    $changed(tap_state) |-> $past(rise) || $past(rise, 2) || $past(rise, 3))
    else $error("controller moved without a test clock rise");
  AST_TDO_ON_FALL: assert property (
    $changed(tdo) |-> $past(fall) || $past(fall, 2) || $past(fall, 3))
    else $error("serial output changed without a test clock fall");
  AST_OE_ON: assert property (
    $rose(tdo.oe) |-> tap_state inside {MBST_SH_IR, MBST_SH_DR})
    else $error("serial output enabled outside shift states");
  AST_OE_OFF: assert property (
    $fell(tdo.oe) |-> !(tap_state inside {MBST_SH_IR, MBST_SH_DR}))
    else $error("serial output released inside a shift state");
  AST_RING_FROM_UPD: assert property (
    $rose(ring_drive_en) || $rose(ring_highz) |->
      $past(tap_state, 2) == MBST_UPD_IR || $past(tap_state, 3) == MBST_UPD_IR)
    else $error("instruction took effect outside update-IR");
  AST_BSR_IN_UPD: assert property (
    $changed(bsr_drive) |->
      $past(tap_state) == MBST_UPD_DR || $past(tap_state, 2) == MBST_UPD_DR)
    else $error("boundary outputs changed outside update-DR");
  AST_RESET_OUT: assert property (
    $rose(reset_n) |-> tap_state == MBST_TLR && !tdo.oe)
    else $error("port not idle after power-up reset");

  // main scenarios reached
  cover property (tap_state == MBST_PAU_DR);
  cover property ($rose(ring_highz));
  cover property ($changed(bsr_drive));
endmodule : mbst_tap_sva

// >>> sim/mbst_ctl_model.sv
`timescale 1ns/1ps
// ----------------------------------------------------------------
// board test controller driving the port pins
// ----------------------------------------------------------------
module mbst_ctl_model
  import mbst_pkg::*;
(
  input wire logic mclk,
  input wire mbst_tdo_t tdo,
  output mbst_pins_t pins
);
  // clock idles low, mode select and data idle high
  initial begin
    pins = 3'h3;
  end

  // one test clock period of 160 ns, output read before the rise
  task automatic clk_bit(input logic tms, input logic tdi,
      output logic tdo_bit, output logic oe_bit);
    @(negedge mclk);
    pins.tms = tms;
    pins.tdi = tdi;
    repeat (15) @(negedge mclk);
    tdo_bit = tdo.oe ? tdo.data : ~tdo.data; // released pin has no keeper
    oe_bit = tdo.oe;
    pins.tck = 1'b1;
    repeat (16) @(negedge mclk);
    pins.tck = 1'b0;
  endtask : clk_bit

  // five high rises then to idle
  task automatic reset_tap();
    logic b;
    logic o;
    repeat (5) clk_bit(1'b1, 1'b1, b, o);
    clk_bit(1'b0, 1'b1, b, o);
  endtask : reset_tap

  // scan from idle back to idle, optional pause before bit pause_at
  task automatic scan(input logic is_ir, input int n,
      input logic [127:0] din, input int pause_at,
      output logic [127:0] dout, output int oe_bad);
    logic b;
    logic o;
    dout = '0;
    oe_bad = 0;
    clk_bit(1'b1, 1'b1, b, o);
    if (is_ir) begin
      clk_bit(1'b1, 1'b1, b, o);
    end
    clk_bit(1'b0, 1'b1, b, o);
    clk_bit(1'b0, 1'b1, b, o);
    for (int i = 0; i < n; i++) begin
      if (i == pause_at && i > 0) begin
        clk_bit(1'b0, 1'b1, b, o);
        oe_bad += (o !== 1'b0);
        clk_bit(1'b0, 1'b1, b, o);
        oe_bad += (o !== 1'b0);
        clk_bit(1'b1, 1'b1, b, o);
        oe_bad += (o !== 1'b0);
        clk_bit(1'b0, 1'b1, b, o);
        oe_bad += (o !== 1'b0);
      end
      clk_bit(i == n - 1 || i + 1 == pause_at, din[i], b, o);
      dout[i] = b;
      oe_bad += (o !== 1'b1);
    end
    clk_bit(1'b1, 1'b1, b, o);
    oe_bad += (o !== 1'b0);
    clk_bit(1'b0, 1'b1, b, o);
  endtask : scan
endmodule : mbst_ctl_model

// >>> sim/memory_boundary_scan_tap_tb.sv
`timescale 1ns/1ps
`include "mbst_consts.svh"
`define MBST_CHK(got, exp) begin \
  tests_run++; \
  if ((got) !== (exp)) begin \
    errors++; \
    $display("Error at %0t: got %h expected %h", $time, got, exp); \
  end \
end

// ----------------------------------------------------------------
// testbench top
// ----------------------------------------------------------------
module memory_boundary_scan_tap_tb;
  import mbst_pkg::*;
  localparam int BSR_W = `MBST_BSR_WIDTH;
  localparam logic [31:0] ID_VAL = 32'h3c96_a5e7; // arbitrary value, lsb one
  localparam logic [127:0] PAT_A = {4{32'h9e37_79b9}};
  localparam logic [127:0] PAT_B = {4{32'h6d2b_c41f}};
  logic mclk = 1'b0;
  logic reset_n;
  mbst_pins_t tap_pins;
  logic [BSR_W-1:0] pin_state;
  mbst_tdo_t tdo;
  logic [BSR_W-1:0] bsr_drive;
  logic ring_drive_en;
  logic ring_highz;
  mbst_state_t tap_state;
  int errors = 0;
  int tests_run = 0;

  // 200 MHz memory clock
  always #2.5 mclk = ~mclk;

  mbst_tap_top #(.BSR_WIDTH(BSR_W), .ID_CODE(ID_VAL)) i_dut (
    .mclk(mclk),
    .reset_n(reset_n),
    .tap_pins(tap_pins),
    .pin_state(pin_state),
    .tdo(tdo),
    .bsr_drive(bsr_drive),
    .ring_drive_en(ring_drive_en),
    .ring_highz(ring_highz),
    .tap_state(tap_state)
  );

  mbst_ctl_model i_ctl (
    .mclk(mclk),
    .tdo(tdo),
    .pins(tap_pins)
  );

  // verdict and end of run
  task automatic finish_test();
    if (errors == 0 && tests_run > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : finish_test

  // state straight after power-up reset
  task automatic t_reset();
    `MBST_CHK(tap_state, MBST_TLR)
    `MBST_CHK(tdo.oe, 1'b0)
    `MBST_CHK(bsr_drive, {BSR_W{1'b0}})
  endtask : t_reset

  // identification code read after reset
  task automatic t_idcode();
    logic [127:0] q;
    int bad;
    logic b;
    logic o;
    i_ctl.reset_tap();
    repeat (2) i_ctl.clk_bit(1'b0, 1'b1, b, o);
    `MBST_CHK(tap_state, MBST_RTI)
    `MBST_CHK(o, 1'b0)
    i_ctl.scan(1'b0, 32, PAT_B, 0, q, bad);
    `MBST_CHK(q[31:0], ID_VAL)
    `MBST_CHK(bad, 0)
  endtask : t_idcode

  // capture pattern of the instruction path, then a bypass pass-through
  task automatic t_bypass();
    logic [127:0] q;
    int bad;
    i_ctl.scan(1'b1, 8, 128'hff, 0, q, bad);
    `MBST_CHK(q[7:0], `MBST_IR_CAPTURE)
    `MBST_CHK(bad, 0)
    i_ctl.scan(1'b0, 9, 128'h0b5, 0, q, bad);
    `MBST_CHK(q[8:0], {8'hb5, 1'b0})
  endtask : t_bypass

  // pin snapshot shifted out across a pause, preload into the latch
  task automatic t_sample();
    logic [127:0] q;
    int bad;
    @(negedge mclk);
    pin_state = PAT_A[BSR_W-1:0];
    i_ctl.scan(1'b1, 8, {120'h0, `MBST_INS_SAMPLE}, 0, q, bad);
    i_ctl.scan(1'b0, BSR_W, PAT_B, 60, q, bad);
    `MBST_CHK(q[BSR_W-1:0], PAT_A[BSR_W-1:0])
    `MBST_CHK(bad, 0)
    `MBST_CHK(bsr_drive, PAT_B[BSR_W-1:0])
  endtask : t_sample

  // clamp, high impedance, bypass, an unused code and extest, each with its effect on the ring controls
  task automatic t_modes();
    logic [127:0] q;
    int bad;
    logic [7:0] codes [5];
    codes = '{`MBST_INS_CLAMP, `MBST_INS_HIGHZ, `MBST_INS_BYPASS, 8'h3c,
              `MBST_INS_EXTEST};
    for (int i = 0; i < 5; i++) begin
      i_ctl.scan(1'b1, 8, {120'h0, codes[i]}, 0, q, bad);
      `MBST_CHK(ring_drive_en, i == 0 || i == 4)
      `MBST_CHK(ring_highz, i == 1)
      if (i < 4) begin
        i_ctl.scan(1'b0, 2, 128'h1, 0, q, bad);
        `MBST_CHK(q[1:0], 2'h2)
      end else begin
        i_ctl.scan(1'b0, BSR_W, PAT_A, 0, q, bad);
        `MBST_CHK(q[BSR_W-1:0], PAT_A[BSR_W-1:0])
        `MBST_CHK(bsr_drive, PAT_A[BSR_W-1:0])
      end
    end
  endtask : t_modes

  // five high rises restore the identification instruction
  task automatic t_tlr();
    logic [127:0] q;
    int bad;
    logic b;
    logic o;
    repeat (5) i_ctl.clk_bit(1'b1, 1'b1, b, o);
    `MBST_CHK(tap_state, MBST_TLR)
    `MBST_CHK(ring_drive_en, 1'b0)
    `MBST_CHK(bsr_drive, PAT_A[BSR_W-1:0])
    i_ctl.clk_bit(1'b0, 1'b1, b, o);
    i_ctl.scan(1'b0, 32, PAT_A, 0, q, bad);
    `MBST_CHK(q[31:0], ID_VAL)
  endtask : t_tlr

  // main sequence
  initial begin
    reset_n = 1'b0;
    pin_state = '0;
    repeat (6) @(negedge mclk);
    reset_n = 1'b1;
    repeat (3) @(negedge mclk);
    t_reset();
    t_idcode();
    t_bypass();
    t_sample();
    t_modes();
    t_tlr();
    finish_test();
  end

  // watchdog against a hang
  initial begin
    #400000;
    errors++;
    finish_test();
  end
endmodule : memory_boundary_scan_tap_tb

bind mbst_tap_top mbst_tap_sva #(.BSR_WIDTH(BSR_WIDTH)) i_sva (
  .mclk(mclk),
  .reset_n(reset_n),
  .tap_pins(tap_pins),
  .pin_state(pin_state),
  .tdo(tdo),
  .bsr_drive(bsr_drive),
  .ring_drive_en(ring_drive_en),
  .ring_highz(ring_highz),
  .tap_state(tap_state)
);
